// ===== durm_host.sv
// Host processor model that drives the parallel register bus.
`timescale 1ns/1ps
module durm_host (
   input  wire       clock,
   output reg  [3:0] addr,
   output reg        read_strobe_n,
   output reg        write_strobe_n,
   output reg  [7:0] wdata,
   input  wire [7:0] rdata
);
   initial begin
      addr = 4'h0;
      wdata = 8'h00;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
   end
   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   // Address and data settle three cycles before the strobe and are inverted once released.
   task access(input logic rd, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge clock);
      addr = a;
      wdata = d;
      repeat (3) @(negedge clock);
      read_strobe_n = !rd;
      write_strobe_n = rd;
      repeat (6) @(negedge clock);
      q = rdata;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      addr = ~a;
      wdata = ~d;
      repeat (3) @(negedge clock);
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      access(1'b0, a, d, q);
   endtask
   task rd(input logic [3:0] a, output logic [7:0] q);
      if (a == 4'h2 || a == 4'hA)
         q = 8'h00;
      else
         access(1'b1, a, 8'h00, q);
   endtask
endmodule // durm_host

// ===== durm_map.vh
// Address map, command codes, field positions and reset values of the host register block.
`ifndef DURM_MAP_VH
`define DURM_MAP_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define DURM_ADDR_MODE_A      4'h0
`define DURM_ADDR_STAT_A      4'h1
`define DURM_ADDR_CMD_A       4'h2
`define DURM_ADDR_HOLD_A      4'h3
`define DURM_ADDR_IPC_ACR     4'h4
`define DURM_ADDR_ISR_IMR     4'h5
`define DURM_ADDR_CT_HIGH     4'h6
`define DURM_ADDR_CT_LOW      4'h7
`define DURM_ADDR_MODE_B      4'h8
`define DURM_ADDR_STAT_B      4'h9
`define DURM_ADDR_CMD_B       4'hA
`define DURM_ADDR_HOLD_B      4'hB
`define DURM_ADDR_USER_FLAG   4'hC
`define DURM_ADDR_IPR_OUTPUT_CONFIG    4'hD
`define DURM_ADDR_START_SET   4'hE
`define DURM_ADDR_STOP_CLR    4'hF

// ----------------------------------------
// Command codes (upper nibble)
// ----------------------------------------
`define DURM_CMD_PTR_ONE      4'h1
`define DURM_CMD_RX_RESET     4'h2
`define DURM_CMD_ERR_RESET    4'h4
`define DURM_CMD_PTR_ZERO     4'hB

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define DURM_M0_WATCHDOG      7
`define DURM_M0_EXT_ONE       0
`define DURM_M0_EXT_TWO       2
`define DURM_M0_RECEIVE_IRQ_LEVEL         6
`define DURM_M1_RTS_CTRL      7
`define DURM_M1_RECEIVE_IRQ_LEVEL         6
`define DURM_M1_ERR_MODE      5
`define DURM_M1_PAR_HI        4
`define DURM_M1_PAR_LO        3
`define DURM_M1_PAR_TYPE      2
`define DURM_M1_LEN_HI        1
`define DURM_M1_LEN_LO        0
`define DURM_PAR_MULTIDROP    2'b11
`define DURM_MB_LOW_READ      4'hF
`define DURM_M0_WR_MASK       8'hF5

// ----------------------------------------
// Reset values and last mode pointer position
// ----------------------------------------
`define DURM_PTR_RESET        2'd1
`define DURM_REG_RESET        8'h00
`define DURM_PRESET_RESET     16'h0000
`define DURM_PTR_LAST         2'd2

`endif

// ===== durm_regs.v
// Host register file of a dual serial controller: decode, mode pointers and control registers.
`timescale 1ns/1ps
`include "durm_map.vh"

// What this block does
// - Per-channel mode pointer advances, stops at third
// - Commands 1x, Bx load pointer one, zero
// - Reset sets each mode pointer to one
// - Reset clears control registers to zero
// - Four address bits; strobes; channel A map
// - Addresses four to seven are shared registers
// - Addresses eight to eleven mirror channel B
// - Flag at twelve; pins read, config write
// - Fourteen/fifteen: timer start/stop, port set/clear
// - First mode bit seven enables watchdog
// - First mode bits zero, two pick extended rates
// - Channel B first mode low nibble reads F
// - Second mode bit six selects receive interrupt
// - Second mode bit five selects block errors
// - Block errors cleared by error or receiver reset
// - Parity mode bits four-three, bit two odd
// - Second mode bit seven gives receiver RTS
// - Multidrop address/data flag from bit two
module durm_regs #(
   parameter WIDTH = 8,
   parameter IN_PINS = 7
) (
   input  wire                clock,
   input  wire                reset_n,
   input  wire [3:0]          addr,
   input  wire                read_strobe_n,
   input  wire                write_strobe_n,
   input  wire [WIDTH-1:0]    wdata,
   input  wire [IN_PINS-1:0]  input_pins,
   input  wire [1:0]          err_events,
   input  wire [WIDTH-1:0]    stat_a_in,
   input  wire [WIDTH-1:0]    stat_b_in,
   input  wire [WIDTH-1:0]    rx_hold_a_in,
   input  wire [WIDTH-1:0]    rx_hold_b_in,
   input  wire [WIDTH-1:0]    input_change_in,
   input  wire [WIDTH-1:0]    irq_status_in,
   input  wire [15:0]         timer_count_in,
   output reg  [WIDTH-1:0]    rdata,
   output reg  [WIDTH-1:0]    output_port,
   output reg  [WIDTH-1:0]    output_config,
   output reg  [WIDTH-1:0]    auxiliary_control,
   output reg  [WIDTH-1:0]    irq_mask,
   output reg  [15:0]         timer_preset,
   output reg  [WIDTH-1:0]    user_flag,
   output reg                 timer_start,
   output reg                 timer_stop,
   output reg  [1:0]          tx_write,
   output reg  [1:0]          rx_read,
   output reg  [WIDTH-1:0]    tx_data,
   output reg  [WIDTH-1:0]    rate_select_a,
   output reg  [WIDTH-1:0]    rate_select_b,
   output reg  [WIDTH-1:0]    command_a,
   output reg  [WIDTH-1:0]    command_b,
   output reg  [1:0]          command_strobe,
   output reg  [1:0]          watchdog_en,
   output reg  [3:0]          ext_rate_sel,
   output reg  [1:0]          rx_irq_full,
   output reg  [1:0]          block_err_mode,
   output reg  [1:0]          block_err,
   output reg  [3:0]          parity_mode,
   output reg  [1:0]          parity_odd,
   output reg  [1:0]          rts_by_rx,
   output reg  [1:0]          addr_flag,
   output reg  [3:0]          char_len
);

   // ----------------------------------------
   // Strobe synchronisers and access edges
   // ----------------------------------------
   reg  [1:0]         rd_sync;
   reg  [1:0]         wr_sync;
   reg                rd_prev;
   reg                wr_prev;
   reg  [3:0]         addr_s1;
   reg  [3:0]         addr_s2;
   reg  [WIDTH-1:0]   wdata_s1;
   reg  [WIDTH-1:0]   wdata_s2;
   reg  [IN_PINS-1:0] pins_s1;
   reg  [IN_PINS-1:0] pins_s2;
   wire               rd_go;
   wire               wr_go;

   // Both strobes are active low; an access happens once, at the falling edge.
   assign rd_go = rd_sync[1] & ~rd_prev;
   assign wr_go = wr_sync[1] & ~wr_prev;

   // Address and write data ride through the same two stages as the strobes, so the host
   // must have them steady by the time a strobe falls and hold them until it rises again.

   always @(posedge clock) begin
      if (!reset_n) begin
         rd_sync  <= 2'b00;
         wr_sync  <= 2'b00;
         rd_prev  <= 1'b0;
         wr_prev  <= 1'b0;
         addr_s1  <= 4'h0;
         addr_s2  <= 4'h0;
         wdata_s1 <= `DURM_REG_RESET;
         wdata_s2 <= `DURM_REG_RESET;
         pins_s1  <= {IN_PINS{1'b0}};
         pins_s2  <= {IN_PINS{1'b0}};
      end else begin
         rd_sync  <= {rd_sync[0], ~read_strobe_n};
         wr_sync  <= {wr_sync[0], ~write_strobe_n};
         rd_prev  <= rd_sync[1];
         wr_prev  <= wr_sync[1];
         addr_s1  <= addr;
         addr_s2  <= addr_s1;
         wdata_s1 <= wdata;
         wdata_s2 <= wdata_s1;
         pins_s1  <= input_pins;
         pins_s2  <= pins_s1;
      end
   end

   // ----------------------------------------
   // Per-channel mode registers and pointers
   // ----------------------------------------
   reg  [WIDTH-1:0] mode_reg_first  [0:1];
   reg  [WIDTH-1:0] mode_reg_second [0:1];
   reg  [WIDTH-1:0] mode_reg_third  [0:1];
   reg  [1:0]       mode_ptr        [0:1];
   wire [WIDTH-1:0] mode_rd         [0:1];
   wire [3:0]       cmd_code;

   assign cmd_code = wdata_s2[7:4];

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
         wire       hit_mode;
         wire       hit_cmd;
         wire [3:0] mode_addr;
         wire [3:0] cmd_addr;
         wire [WIDTH-1:0] first_rd;

         assign mode_addr = ch ? `DURM_ADDR_MODE_B : `DURM_ADDR_MODE_A;
         assign cmd_addr  = ch ? `DURM_ADDR_CMD_B : `DURM_ADDR_CMD_A;
         // Reads and writes alike move the pointer on.
         assign hit_mode  = (rd_go | wr_go) && addr_s2 == mode_addr;
         assign hit_cmd   = wr_go && addr_s2 == cmd_addr;
         // Channel B hides its low nibble behind a fixed pattern.
         assign first_rd  = ch ? {mode_reg_first[ch][7:4], `DURM_MB_LOW_READ}
                               : mode_reg_first[ch];
         assign mode_rd[ch] = (mode_ptr[ch] == 2'd0) ? first_rd :
                              (mode_ptr[ch] == 2'd1) ? mode_reg_second[ch] :
                              mode_reg_third[ch];

         always @(posedge clock) begin
            if (!reset_n) begin
               mode_ptr[ch]        <= `DURM_PTR_RESET;
               mode_reg_first[ch]  <= `DURM_REG_RESET;
               mode_reg_second[ch] <= `DURM_REG_RESET;
               mode_reg_third[ch]  <= `DURM_REG_RESET;
               block_err[ch]       <= 1'b0;
            end else begin
               // A pointer command outranks an access; the pointer then stays on the third
               // register until a command reloads it.
               if (hit_cmd && cmd_code == `DURM_CMD_PTR_ONE) begin
                  mode_ptr[ch] <= 2'd1;
               end else if (hit_cmd && cmd_code == `DURM_CMD_PTR_ZERO) begin
                  mode_ptr[ch] <= 2'd0;
               end else if (hit_mode && mode_ptr[ch] != `DURM_PTR_LAST) begin
                  mode_ptr[ch] <= mode_ptr[ch] + 2'd1;
               end
               if (hit_mode && wr_go) begin
                  case (mode_ptr[ch])
                     2'd0: begin
                        // Bits 3 and 1 are forced to zero whatever is written.
                        mode_reg_first[ch] <= wdata_s2 & `DURM_M0_WR_MASK;
                     end
                     2'd1: begin
                        mode_reg_second[ch] <= wdata_s2;
                     end
                     default: begin
                        mode_reg_third[ch] <= wdata_s2;
                     end
                  endcase
               end
               // An arriving error outranks a clear in the same cycle.
               if (err_events[ch] && mode_reg_second[ch][`DURM_M1_ERR_MODE]) begin
                  block_err[ch] <= 1'b1;
               end else if (hit_cmd && (cmd_code == `DURM_CMD_ERR_RESET ||
                                        cmd_code == `DURM_CMD_RX_RESET)) begin
                  block_err[ch] <= 1'b0;
               end
            end
         end

         // Field decodes are registered so every output leaves a flip-flop.
         always @(posedge clock) begin
            if (!reset_n) begin
               watchdog_en[ch]          <= 1'b0;
               ext_rate_sel[2*ch+1:2*ch] <= 2'b00;
               rx_irq_full[ch]          <= 1'b0;
               block_err_mode[ch]       <= 1'b0;
               parity_mode[2*ch+1:2*ch] <= 2'b00;
               parity_odd[ch]           <= 1'b0;
               rts_by_rx[ch]            <= 1'b0;
               addr_flag[ch]            <= 1'b0;
               char_len[2*ch+1:2*ch]    <= 2'b00;
            end else begin
               watchdog_en[ch] <= mode_reg_first[ch][`DURM_M0_WATCHDOG];
               ext_rate_sel[2*ch+1:2*ch] <= {mode_reg_first[ch][`DURM_M0_EXT_TWO],
                                             mode_reg_first[ch][`DURM_M0_EXT_ONE]};
               rx_irq_full[ch] <= mode_reg_second[ch][`DURM_M1_RECEIVE_IRQ_LEVEL];
               block_err_mode[ch] <= mode_reg_second[ch][`DURM_M1_ERR_MODE];
               parity_mode[2*ch+1:2*ch] <= mode_reg_second[ch][`DURM_M1_PAR_HI:
                                                              `DURM_M1_PAR_LO];
               parity_odd[ch] <= mode_reg_second[ch][`DURM_M1_PAR_TYPE];
               rts_by_rx[ch] <= mode_reg_second[ch][`DURM_M1_RTS_CTRL];
               addr_flag[ch] <= (mode_reg_second[ch][`DURM_M1_PAR_HI:`DURM_M1_PAR_LO] ==
                                 `DURM_PAR_MULTIDROP) &
                                mode_reg_second[ch][`DURM_M1_PAR_TYPE];
               char_len[2*ch+1:2*ch] <= mode_reg_second[ch][`DURM_M1_LEN_HI:
                                                           `DURM_M1_LEN_LO];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Shared and per-channel write registers
   // ----------------------------------------
   always @(posedge clock) begin
      if (!reset_n) begin
         output_port       <= `DURM_REG_RESET;
         output_config     <= `DURM_REG_RESET;
         auxiliary_control <= `DURM_REG_RESET;
         irq_mask          <= `DURM_REG_RESET;
         timer_preset      <= `DURM_PRESET_RESET;
         user_flag         <= `DURM_REG_RESET;
         rate_select_a     <= `DURM_REG_RESET;
         rate_select_b     <= `DURM_REG_RESET;
         command_a         <= `DURM_REG_RESET;
         command_b         <= `DURM_REG_RESET;
         tx_data           <= `DURM_REG_RESET;
         tx_write          <= 2'b00;
         command_strobe    <= 2'b00;
      end else begin
         tx_write       <= 2'b00;
         command_strobe <= 2'b00;
         if (wr_go) begin
            case (addr_s2)
               `DURM_ADDR_STAT_A:     rate_select_a <= wdata_s2;
               `DURM_ADDR_CMD_A: begin
                  command_a         <= wdata_s2;
                  command_strobe[0] <= 1'b1;
               end
               `DURM_ADDR_HOLD_A: begin
                  tx_data     <= wdata_s2;
                  tx_write[0] <= 1'b1;
               end
               `DURM_ADDR_IPC_ACR:    auxiliary_control <= wdata_s2;
               `DURM_ADDR_ISR_IMR:    irq_mask <= wdata_s2;
               // The two preset bytes load on their own; nothing pairs them.
               `DURM_ADDR_CT_HIGH:    timer_preset[15:8] <= wdata_s2;
               `DURM_ADDR_CT_LOW:     timer_preset[7:0] <= wdata_s2;
               `DURM_ADDR_STAT_B:     rate_select_b <= wdata_s2;
               `DURM_ADDR_CMD_B: begin
                  command_b         <= wdata_s2;
                  command_strobe[1] <= 1'b1;
               end
               `DURM_ADDR_HOLD_B: begin
                  tx_data     <= wdata_s2;
                  tx_write[1] <= 1'b1;
               end
               `DURM_ADDR_USER_FLAG:  user_flag <= wdata_s2;
               `DURM_ADDR_IPR_OUTPUT_CONFIG:   output_config <= wdata_s2;
               // Set and clear act on the current port value; unmarked bits keep their level.
               `DURM_ADDR_START_SET:  output_port <= output_port | wdata_s2;
               `DURM_ADDR_STOP_CLR:   output_port <= output_port & ~wdata_s2;
               default: begin
                  // Mode addresses are served by the per-channel logic above.
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // Read port and read side effects
   // ----------------------------------------
   // Reads change nothing except the timer commands, holding pops and mode pointers; a strobe held low
   // fires each of these pulses only once.
   always @(posedge clock) begin
      if (!reset_n) begin
         rdata       <= `DURM_REG_RESET;
         timer_start <= 1'b0;
         timer_stop  <= 1'b0;
         rx_read     <= 2'b00;
      end else begin
         timer_start <= 1'b0;
         timer_stop  <= 1'b0;
         rx_read     <= 2'b00;
         if (rd_go) begin
            case (addr_s2)
               `DURM_ADDR_MODE_A:     rdata <= mode_rd[0];
               `DURM_ADDR_STAT_A:     rdata <= stat_a_in;
               `DURM_ADDR_HOLD_A: begin
                  rdata      <= rx_hold_a_in;
                  rx_read[0] <= 1'b1;
               end
               `DURM_ADDR_IPC_ACR:    rdata <= input_change_in;
               `DURM_ADDR_ISR_IMR:    rdata <= irq_status_in;
               `DURM_ADDR_CT_HIGH:    rdata <= timer_count_in[15:8];
               `DURM_ADDR_CT_LOW:     rdata <= timer_count_in[7:0];
               `DURM_ADDR_MODE_B:     rdata <= mode_rd[1];
               `DURM_ADDR_STAT_B:     rdata <= stat_b_in;
               `DURM_ADDR_HOLD_B: begin
                  rdata      <= rx_hold_b_in;
                  rx_read[1] <= 1'b1;
               end
               `DURM_ADDR_USER_FLAG:  rdata <= user_flag;
               // The spare top bit of the input port reads as zero.
               `DURM_ADDR_IPR_OUTPUT_CONFIG:   rdata <= {1'b0, pins_s2};
               `DURM_ADDR_START_SET: begin
                  rdata       <= `DURM_REG_RESET;
                  timer_start <= 1'b1;
               end
               `DURM_ADDR_STOP_CLR: begin
                  rdata      <= `DURM_REG_RESET;
                  timer_stop <= 1'b1;
               end
               default: begin
                  // The two command addresses answer zero and touch nothing.
                  rdata <= `DURM_REG_RESET;
               end
            endcase
         end
      end
   end

endmodule // durm_regs

// ===== durm_regs_properties.sv
// Concurrent checks on the ports of the host register block.
`timescale 1ns/1ps
module durm_regs_properties #(
   parameter WIDTH = 8
) (
   input wire             clock,
   input wire             reset_n,
   input wire [3:0]       addr,
   input wire             read_strobe_n,
   input wire             write_strobe_n,
   input wire [WIDTH-1:0] wdata,
   input wire [WIDTH-1:0] stat_a_in,
   input wire [WIDTH-1:0] rdata,
   input wire [WIDTH-1:0] output_port,
   input wire [WIDTH-1:0] user_flag,
   input wire [WIDTH-1:0] irq_mask,
   input wire             timer_start,
   input wire             timer_stop,
   input wire [1:0]       tx_write,
   input wire [1:0]       rx_read,
   input wire [1:0]       addr_flag,
   input wire [3:0]       parity_mode
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   property p_reset;
      $rose(reset_n) |-> output_port == 8'h00 && user_flag == 8'h00 && irq_mask == 8'h00;
   endproperty
   a_reset: assert property (p_reset)
      else $error("registers not cleared by reset");
   property p_start;
      $fell(read_strobe_n) && addr == 4'hE |-> ##[3:5] timer_start;
   endproperty
   a_start: assert property (p_start)
      else $error("no counter start after read of 14");
   property p_stop;
      $fell(read_strobe_n) && addr == 4'hF |-> ##[3:5] timer_stop;
   endproperty
   a_stop: assert property (p_stop)
      else $error("no counter stop after read of 15");
   property p_one_pulse;
      timer_start |=> !timer_start;
   endproperty
   a_one_pulse: assert property (p_one_pulse)
      else $error("counter start longer than one cycle");
   property p_tx_write;
      $fell(write_strobe_n) && addr == 4'h3 |-> ##[3:5] tx_write == 2'b01;
   endproperty
   a_tx_write: assert property (p_tx_write)
      else $error("no channel A transmit write");
   property p_rx_read;
      $fell(read_strobe_n) && addr == 4'hB |-> ##[3:5] rx_read == 2'b10;
   endproperty
   a_rx_read: assert property (p_rx_read)
      else $error("no channel B receive read");
   property p_set;
      $fell(write_strobe_n) && addr == 4'hE |-> ##[3:5] (output_port & wdata) == wdata;
   endproperty
   a_set: assert property (p_set)
      else $error("output bits not set");
   property p_clear;
      $fell(write_strobe_n) && addr == 4'hF |-> ##[3:5] (output_port & wdata) == 8'h00;
   endproperty
   a_clear: assert property (p_clear)
      else $error("output bits not cleared");
   property p_addr_flag;
      addr_flag[0] |-> parity_mode[1:0] == 2'b11;
   endproperty
   a_addr_flag: assert property (p_addr_flag)
      else $error("address flag outside multidrop");
   property p_status;
      $fell(read_strobe_n) && addr == 4'h1 |-> ##[3:5] rdata == stat_a_in;
   endproperty
   a_status: assert property (p_status)
      else $error("status read mismatch");
   c_start: cover property ($rose(timer_start));
   c_flag: cover property ($rose(addr_flag[0]));
   c_tx: cover property ($rose(tx_write[0]));
endmodule // durm_regs_properties

bind durm_regs durm_regs_properties #(.WIDTH(WIDTH)) u_durm_regs_properties (.clock, .reset_n,
   .addr, .read_strobe_n, .write_strobe_n, .wdata, .stat_a_in, .rdata, .output_port,
   .user_flag, .irq_mask, .timer_start, .timer_stop, .tx_write, .rx_read, .addr_flag,
   .parity_mode);

// ===== durm_regs_test.sv
// Self-checking testbench of the host register block.
`timescale 1ns/1ps
module durm_regs_test;
   reg          clock, reset_n;
   reg  [1:0]   err_events;
   reg  [6:0]   input_pins;
   reg  [7:0]   stat_a_in, stat_b_in, rx_hold_a_in, rx_hold_b_in, input_change_in, irq_status_in;
   reg  [15:0]  timer_count_in;
   wire [3:0]   addr, ext_rate_sel, parity_mode, char_len;
   wire [7:0]   wdata, rdata, output_port, output_config, auxiliary_control, irq_mask;
   wire [7:0]   user_flag, tx_data, rate_select_a, rate_select_b, command_a, command_b;
   wire [15:0]  timer_preset;
   wire [1:0]   tx_write, rx_read, command_strobe, watchdog_en, rx_irq_full, block_err_mode;
   wire [1:0]   block_err, parity_odd, rts_by_rx, addr_flag;
   wire         read_strobe_n, write_strobe_n, timer_start, timer_stop;
   integer      n_errors, check_count, cycles, n_start, n_stop, n_cmd_a, n_cmd_b, k, i;
   logic [7:0]  q;
   logic [3:0]  rd_list [0:8] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hB, 4'hD};
   logic [3:0]  wr_list [0:11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB,
                                   4'hC, 4'hD};

   durm_regs u_durm_regs (.clock, .reset_n, .addr, .read_strobe_n, .write_strobe_n, .wdata,
      .input_pins, .err_events, .stat_a_in, .stat_b_in, .rx_hold_a_in, .rx_hold_b_in,
      .input_change_in, .irq_status_in, .timer_count_in, .rdata, .output_port, .output_config,
      .auxiliary_control, .irq_mask, .timer_preset, .user_flag, .timer_start, .timer_stop,
      .tx_write, .rx_read, .tx_data, .rate_select_a, .rate_select_b, .command_a, .command_b,
      .command_strobe, .watchdog_en, .ext_rate_sel, .rx_irq_full, .block_err_mode, .block_err,
      .parity_mode, .parity_odd, .rts_by_rx, .addr_flag, .char_len);
   durm_host u_durm_host (.clock, .addr, .read_strobe_n, .write_strobe_n, .wdata, .rdata);

   always #12.5 clock = ~clock;
   always @(posedge clock) begin
      cycles = cycles + 1;
      if (timer_start === 1'b1) n_start = n_start + 1;
      if (timer_stop === 1'b1) n_stop = n_stop + 1;
      if (command_strobe[0] === 1'b1) n_cmd_a = n_cmd_a + 1;
      if (command_strobe[1] === 1'b1) n_cmd_b = n_cmd_b + 1;
      if (cycles == 4000) begin
         n_errors = n_errors + 1;
         conclude();
      end
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task conclude();
      $display("errors=%0d checks=%0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count = check_count + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task rdchk(input logic [3:0] a, input logic [7:0] exp);
      u_durm_host.rd(a, q);
      chk(q, exp);
   endtask
   task err_pulse();
      @(negedge clock);
      err_events = 2'b01;
      @(negedge clock);
      err_events = 2'b00;
      repeat (4) @(negedge clock);
   endtask
   function logic [7:0] exp_rd(input logic [3:0] a);
      case (a)
         4'h1: exp_rd = stat_a_in;
         4'h3: exp_rd = rx_hold_a_in;
         4'h4: exp_rd = input_change_in;
         4'h5: exp_rd = irq_status_in;
         4'h6: exp_rd = timer_count_in[15:8];
         4'h7: exp_rd = timer_count_in[7:0];
         4'h9: exp_rd = stat_b_in;
         4'hB: exp_rd = rx_hold_b_in;
         default: exp_rd = {1'b0, input_pins};
      endcase
   endfunction
   function logic [7:0] obs(input logic [3:0] a);
      case (a)
         4'h1: obs = rate_select_a;
         4'h2: obs = command_a;
         4'h4: obs = auxiliary_control;
         4'h5: obs = irq_mask;
         4'h6: obs = timer_preset[15:8];
         4'h7: obs = timer_preset[7:0];
         4'h9: obs = rate_select_b;
         4'hA: obs = command_b;
         4'hC: obs = user_flag;
         4'hD: obs = output_config;
         default: obs = tx_data;
      endcase
   endfunction
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset();
      chk({output_port, user_flag}, 16'h0000);
      chk({irq_mask, auxiliary_control}, 16'h0000);
      chk(timer_preset, 16'h0000);
   endtask
   // Commands keep the enable nibble at zero so the channels stay disabled.
   task t_mode();
      u_durm_host.wr(4'h0, 8'hFE);
      chk({rts_by_rx, rx_irq_full, block_err_mode, parity_odd}, 16'h0055);
      chk({parity_mode, char_len}, 16'h0032);
      chk(addr_flag, 16'h0001);
      u_durm_host.wr(4'h0, 8'h01);
      u_durm_host.wr(4'h0, 8'h02);
      rdchk(4'h0, 8'h02);
      u_durm_host.wr(4'h2, 8'hB0);
      u_durm_host.wr(4'h0, 8'h81);
      chk({watchdog_en, ext_rate_sel}, 16'h0011);
      rdchk(4'h0, 8'hFE);
      rdchk(4'h0, 8'h02);
      u_durm_host.wr(4'h2, 8'h10);
      rdchk(4'h0, 8'hFE);
   endtask
   task t_chan_b();
      u_durm_host.wr(4'hA, 8'hB0);
      u_durm_host.wr(4'h8, 8'h84);
      chk({watchdog_en, ext_rate_sel}, 16'h0039);
      u_durm_host.wr(4'hA, 8'hB0);
      rdchk(4'h8, 8'h8F);
      rdchk(4'h0, 8'h02);
   endtask
   task t_blkerr();
      err_pulse();
      chk(block_err, 16'h0001);
      u_durm_host.wr(4'h2, 8'h40);
      chk(block_err, 16'h0000);
      err_pulse();
      chk(block_err, 16'h0001);
      u_durm_host.wr(4'h2, 8'h20);
      chk(block_err, 16'h0000);
   endtask
   task t_map();
      for (k = 0; k < 2; k = k + 1) begin
         stat_a_in = 8'h13 + k;
         stat_b_in = 8'h24 + k;
         rx_hold_a_in = 8'h35 + k;
         rx_hold_b_in = 8'h46 + k;
         input_change_in = 8'h57 + k;
         irq_status_in = 8'h68 + k;
         timer_count_in = 16'h79A0 + k;
         input_pins = 7'h2B + k;
         for (i = 0; i < 9; i = i + 1)
            rdchk(rd_list[i], exp_rd(rd_list[i]));
      end
      for (i = 0; i < 12; i = i + 1) begin
         u_durm_host.wr(wr_list[i], {wr_list[i], 4'h0});
         chk(obs(wr_list[i]), {wr_list[i], 4'h0});
      end
      rdchk(4'hC, 8'hC0);
   endtask
   task t_port();
      u_durm_host.wr(4'hE, 8'hF0);
      u_durm_host.wr(4'hE, 8'h0C);
      chk(output_port, 16'h00FC);
      u_durm_host.wr(4'hF, 8'h30);
      chk(output_port, 16'h00CC);
      rdchk(4'hE, 8'h00);
      rdchk(4'hF, 8'h00);
      chk({n_start[7:0], n_stop[7:0]}, 16'h0101);
      chk({n_cmd_a[7:0], n_cmd_b[7:0]}, 16'h0503);
      chk(output_port, 16'h00CC);
   endtask

   initial begin
      {clock, reset_n, err_events, input_pins} = 0;
      {stat_a_in, stat_b_in, rx_hold_a_in, rx_hold_b_in} = 0;
      {input_change_in, irq_status_in, timer_count_in} = 0;
      {n_errors, check_count, cycles, n_start, n_stop, n_cmd_a, n_cmd_b} = 0;
      repeat (4) @(negedge clock);
      reset_n = 1'b1;
      t_reset();
      t_mode();
      t_chan_b();
      t_blkerr();
      t_map();
      t_port();
      conclude();
   end
endmodule // durm_regs_test
